/* File: logic/ext_line_irq_cfg.svh */
// Constants for the external line interrupt and event controller.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`ifndef EXT_LINE_IRQ_CFG_SVH
`define EXT_LINE_IRQ_CFG_SVH

`define OFS_INTERRUPT_UNMASK 8'h00
`define OFS_EVENT_UNMASK 8'h04
`define OFS_RISING_EDGE_SELECT 8'h08
`define OFS_FALLING_EDGE_SELECT 8'h0C
`define OFS_SOFTWARE_TRIGGER 8'h10
`define OFS_PENDING_FLAGS 8'h14

`define RST_INTERRUPT_UNMASK 32'h7F84_0000
`define RST_EVENT_UNMASK 32'h0000_0000
`define RST_EDGE_SELECT 32'h0000_0000
`define RST_SOFTWARE_TRIGGER 32'h0000_0000
`define RST_PENDING_FLAGS 32'h0000_0000

// Implemented bits of the edge-select registers: 31, 22:19, 17:0
`define EDGE_SELECT_IMPL 32'h807B_FFFF

`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

/* File: logic/ext_line_irq_pkg.sv */
// Types for the external line interrupt and event controller.
// Assumes the constants header is included by the design files.
package ext_line_irq_pkg;

    typedef enum logic [1:0] {
        WR_IDLE = 2'h0,
        WR_RESP = 2'h1
    } wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h0,
        RD_DATA = 2'h1
    } rd_state_t;

endpackage

/* File: logic/line_sync_edge.sv */
// One-line synchroniser and edge detector.
// Assumes the line input may change at any clock edge.
`timescale 1ns/1ps
module line_sync_edge (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Line
    input wire logic line_in,
    output logic rise,
    output logic fall
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = line_in;
        st_d.s2 = st_q.s1;
        st_d.prev = st_q.s2;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rise = st_q.s2 & ~st_q.prev;
    assign fall = ~st_q.s2 & st_q.prev;

endmodule

/* File: logic/line_trigger.sv */
// Per-line trigger combining edges, select bits and the software request.
// Assumes the edges arrive as one-cycle pulses from the synchroniser.
`timescale 1ns/1ps
module line_trigger (
    // Edges
    input wire logic rise,
    input wire logic fall,
    // Configuration
    input wire logic rise_select_bit,
    input wire logic fall_select_bit,
    input wire logic select_written,
    // Software
    input wire logic soft_fire,
    // Result
    output logic fire
);

    logic hw_edge;

    assign hw_edge = (rise & rise_select_bit) | (fall & fall_select_bit);
    assign fire = (hw_edge & ~select_written) | soft_fire;

endmodule

/* File: logic/ext_line_irq_event_ctrl.sv */
// External line interrupt and event controller with an AXI4-Lite slave.
// Assumes line inputs from pins or peripherals, one clock and sync reset.
//
// How it works
// - Six 32-bit registers at byte offsets 0x00 to 0x14.
// - Interrupt-unmask bit zero blocks the line's request; one passes it.
// - Interrupt-unmask resets to 0x7F840000.
// - Event-unmask bit gates the line's event pulse; resets to zero.
// - Rising select bits for lines 0-17, 19-22, 31; others reserved.
// - Falling select bits for the same lines; reserved bits read zero.
// - An edge coinciding with an edge-select write is ignored.
// - Rising and falling may both be enabled on one line.
// - Enabled edge with unmasked interrupt sets pending and raises request.
// - Enabled edge with unmasked event gives a one-cycle pulse, pending untouched.
// - Writing one to pending clears it, its request and its trigger bit.
// - Writing one to a clear trigger bit triggers the line through the masks.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "ext_line_irq_cfg.svh"
module ext_line_irq_event_ctrl
    import ext_line_irq_pkg::*;
#(
    parameter int LINES = 32
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Lines and results
    input wire logic [LINES-1:0] ext_trigger_line,
    output logic [LINES-1:0] irq_request,
    output logic [LINES-1:0] event_pulse,
    output logic irq
);

    typedef struct packed {
        logic [31:0] imask;
        logic [31:0] emask;
        logic [31:0] rsel;
        logic [31:0] fsel;
        logic [31:0] swtrig;
        logic [31:0] pend;
        logic [LINES-1:0] evp;
        logic irq;
        wr_state_t wst;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] bresp;
        rd_state_t rst;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic awrdy;
        logic wrdy;
        logic bvld;
        logic arrdy;
        logic rvld;
    } ctrl_state_t;

    ctrl_state_t st_q;
    ctrl_state_t st_d;

    logic [LINES-1:0] rise;
    logic [LINES-1:0] fall;
    logic [LINES-1:0] fire;
    logic [LINES-1:0] soft_fire;
    logic wr_go;
    logic sel_r_wr;
    logic sel_f_wr;
    logic [31:0] wmask;
    logic [31:0] wbits;
    logic sel_wr;
    logic [LINES-1:0] pend_set;
    logic [LINES-1:0] pend_clr;
    logic [LINES-1:0] ev_set;
    logic [31:0] rd_word;
    logic rd_err;

    ////////////////////////////////////////////////////////////////////////////

    // Write is performed once both address and data are held
    assign wr_go = (st_q.wst == WR_IDLE) && st_q.aw_got && st_q.w_got;
    assign wmask = {{8{st_q.wstrb[3]}}, {8{st_q.wstrb[2]}},
                    {8{st_q.wstrb[1]}}, {8{st_q.wstrb[0]}}};
    assign wbits = st_q.wdata & wmask;
    assign sel_r_wr = wr_go && (st_q.awaddr == `OFS_RISING_EDGE_SELECT);
    assign sel_f_wr = wr_go && (st_q.awaddr == `OFS_FALLING_EDGE_SELECT);
    // Rising edge on a bit newly written to one while it was zero
    assign soft_fire = (wr_go && (st_q.awaddr == `OFS_SOFTWARE_TRIGGER)) ?
                       (wbits[LINES-1:0] & ~st_q.swtrig[LINES-1:0]) : '0;

    // Any edge-select write blanks edge detection on every line this cycle
    assign sel_wr = sel_r_wr | sel_f_wr;
    // A performed write of ones to the pending word clears those lines
    assign pend_clr = (wr_go && (st_q.awaddr == `OFS_PENDING_FLAGS)) ?
                      wbits[LINES-1:0] : '0;
    // Lines that fire with their interrupt or event open
    assign pend_set = fire & st_q.imask[LINES-1:0];
    assign ev_set = fire & st_q.emask[LINES-1:0];

    // One synchroniser and trigger per line
    genvar g;
    generate
        for (g = 0; g < LINES; g++) begin : g_line
            line_sync_edge u_sync (
                .aclk(aclk),
                .aresetn(aresetn),
                .line_in(ext_trigger_line[g]),
                .rise(rise[g]),
                .fall(fall[g])
            );
            line_trigger u_trig (
                .rise(rise[g]),
                .fall(fall[g]),
                .rise_select_bit(st_q.rsel[g]),
                .fall_select_bit(st_q.fsel[g]),
                .select_written(sel_wr),
                .soft_fire(soft_fire[g]),
                .fire(fire[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////

    // Register read mux; unmapped words read zero with an error response
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_err = 1'b0;
        case ({s_axi_araddr[7:2], 2'b00})
            `OFS_INTERRUPT_UNMASK: begin
                rd_word = st_q.imask;
            end
            `OFS_EVENT_UNMASK: begin
                rd_word = st_q.emask;
            end
            `OFS_RISING_EDGE_SELECT: begin
                rd_word = st_q.rsel;
            end
            `OFS_FALLING_EDGE_SELECT: begin
                rd_word = st_q.fsel;
            end
            `OFS_SOFTWARE_TRIGGER: begin
                rd_word = st_q.swtrig;
            end
            `OFS_PENDING_FLAGS: begin
                rd_word = st_q.pend;
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        st_d = st_q;
        // Write channels, taken in either order
        if (s_axi_awvalid && !st_q.aw_got) begin
            st_d.aw_got = 1'b1;
            st_d.awaddr = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && !st_q.w_got) begin
            st_d.w_got = 1'b1;
            st_d.wdata = s_axi_wdata;
            st_d.wstrb = s_axi_wstrb;
        end
        case (st_q.wst)
            WR_IDLE: begin
                if (wr_go) begin
                    st_d.wst = WR_RESP;
                    st_d.bresp = `AXI_RESP_OKAY;
                    case (st_q.awaddr)
                        `OFS_INTERRUPT_UNMASK: begin
                            st_d.imask = (st_q.imask & ~wmask) | wbits;
                        end
                        `OFS_EVENT_UNMASK: begin
                            st_d.emask = (st_q.emask & ~wmask) | wbits;
                        end
                        `OFS_RISING_EDGE_SELECT: begin
                            st_d.rsel = ((st_q.rsel & ~wmask) | wbits) & `EDGE_SELECT_IMPL;
                        end
                        `OFS_FALLING_EDGE_SELECT: begin
                            st_d.fsel = ((st_q.fsel & ~wmask) | wbits) & `EDGE_SELECT_IMPL;
                        end
                        `OFS_SOFTWARE_TRIGGER: begin
                            st_d.swtrig = st_q.swtrig | wbits;
                        end
                        `OFS_PENDING_FLAGS: begin
                            st_d.pend[LINES-1:0] = st_q.pend[LINES-1:0] & ~pend_clr;
                            st_d.swtrig = st_q.swtrig & ~wbits;
                        end
                        default: begin
                            st_d.bresp = `AXI_RESP_SLVERR;
                        end
                    endcase
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    st_d.wst = WR_IDLE;
                    st_d.aw_got = 1'b0;
                    st_d.w_got = 1'b0;
                end
            end
            default: begin
                st_d.wst = WR_IDLE;
            end
        endcase
        // Hardware set beats software clear in the same cycle
        st_d.pend[LINES-1:0] = st_d.pend[LINES-1:0] | pend_set;
        st_d.evp = ev_set;
        st_d.irq = |(st_d.pend[LINES-1:0]);
        // Read channel
        case (st_q.rst)
            RD_IDLE: begin
                if (s_axi_arvalid) begin
                    st_d.rst = RD_DATA;
                    st_d.rdata = rd_word;
                    st_d.rresp = rd_err ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
                end
            end
            RD_DATA: begin
                if (s_axi_rready) begin
                    st_d.rst = RD_IDLE;
                end
            end
            default: begin
                st_d.rst = RD_IDLE;
            end
        endcase

        // Handshake outputs are registered copies of the next channel state
        st_d.awrdy = ~st_d.aw_got;
        st_d.wrdy = ~st_d.w_got;
        st_d.bvld = (st_d.wst == WR_RESP);
        st_d.arrdy = (st_d.rst == RD_IDLE);
        st_d.rvld = (st_d.rst == RD_DATA);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
            st_q.imask <= `RST_INTERRUPT_UNMASK;
            st_q.emask <= `RST_EVENT_UNMASK;
            st_q.rsel <= `RST_EDGE_SELECT;
            st_q.fsel <= `RST_EDGE_SELECT;
            st_q.swtrig <= `RST_SOFTWARE_TRIGGER;
            st_q.pend <= `RST_PENDING_FLAGS;
            st_q.wst <= WR_IDLE;
            st_q.rst <= RD_IDLE;
            // Ready outputs come up high so a request may follow reset at once
            st_q.awrdy <= 1'b1;
            st_q.wrdy <= 1'b1;
            st_q.arrdy <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Ready flags are registered state; no combinational path from valid
    assign s_axi_awready = st_q.awrdy;
    assign s_axi_wready = st_q.wrdy;
    assign s_axi_bvalid = st_q.bvld;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = st_q.arrdy;
    assign s_axi_rvalid = st_q.rvld;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;
    assign irq_request = st_q.pend[LINES-1:0];
    assign event_pulse = st_q.evp;
    assign irq = st_q.irq;

endmodule

/* File: test/line_source_model.sv */
// Model of the line sources and of the core that takes event pulses.
// Assumes the bench sets wanted line levels and one clock drives all.
`timescale 1ns/1ps
module line_source_model (
    // Clock
    input wire logic aclk,
    // Bench side
    input wire logic [31:0] level_req,
    output logic [7:0] n_pulses = 8'h00,
    // Controller side
    input wire logic [31:0] event_pulse,
    output logic [31:0] lines = 32'h0000_0000
);
    // Lines move only at clock edges, so no glitch reaches the controller
    always @(posedge aclk) begin
        lines <= level_req;
        n_pulses <= n_pulses + 8'($countones(event_pulse));
    end
endmodule

/* File: test/ext_line_irq_assertions.sv */
// Port checker for the line interrupt and event controller.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "ext_line_irq_cfg.svh"
module ext_line_irq_assertions #(
    parameter int LINES = 32
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Results
    input wire logic [LINES-1:0] irq_request,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    wr_answer_a: assert property (wr_take |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
        else $error("read data late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    rd_unmapped_a: assert property (rd_take and s_axi_araddr > 8'h17 |=>
        s_axi_rresp == `AXI_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
    rd_reserved_a: assert property (rd_take and (s_axi_araddr[7:2] inside {6'h02, 6'h03}) |=>
        (s_axi_rdata & ~`EDGE_SELECT_IMPL) == 32'h0) else $error("reserved edge bit set");
    irq_on_a: assert property ((irq_request != 0) [*2] |-> irq)
        else $error("irq low with request");
    irq_off_a: assert property ((irq_request == 0) [*2] |-> !irq)
        else $error("irq high without request");
    pend_clear_a: assert property (|($past(irq_request) & ~irq_request) |->
        s_axi_bvalid || $past(s_axi_bvalid)) else $error("request cleared without write");
    rst_quiet_a: assert property ($rose(aresetn) |-> s_axi_awready && s_axi_arready &&
        !s_axi_bvalid && !s_axi_rvalid && irq_request == 0) else $error("bad reset state");
endmodule
bind ext_line_irq_event_ctrl ext_line_irq_assertions #(.LINES(LINES)) chk_u (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq_request, .irq);

/* File: test/tb.sv */
// Self-checking bench for the line interrupt and event controller.
// Assumes the package, header and line model are compiled first.
`timescale 1ns/1ps
`include "ext_line_irq_cfg.svh"
module tb;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wd;
        logic [31:0] rd;
        logic [1:0] resp;
    } row_t;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, n_pulses;
    logic [31:0] s_axi_wdata = 32'h0, level_req = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, irq_request, event_pulse, lines;
    int mismatches = 0;
    int n_checks = 0;
    row_t rows [6] = '{
        '{8'h00, 32'hFFFF_FFFF, 32'hFFFF_FFFF, `AXI_RESP_OKAY},
        '{8'h04, 32'hA5A5_A5A5, 32'hA5A5_A5A5, `AXI_RESP_OKAY},
        '{8'h08, 32'hFFFF_FFFF, `EDGE_SELECT_IMPL, `AXI_RESP_OKAY},
        '{8'h0C, 32'hFFFF_FFFF, `EDGE_SELECT_IMPL, `AXI_RESP_OKAY},
        '{8'h18, 32'h0000_0001, 32'h0000_0000, `AXI_RESP_SLVERR},
        '{8'h04, 32'h0000_0000, 32'h0000_0000, `AXI_RESP_OKAY}
    };
    ext_line_irq_event_ctrl #(.LINES(32)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_trigger_line(lines),
        .irq_request, .event_pulse, .irq);
    line_source_model src_u (.aclk, .level_req, .n_pulses, .event_pulse, .lines);
    always #20 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic fail_wait();
        mismatches++;
        $display("mismatch at %0t: wait ran out", $time);
        summarize();
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic awp, wp, ak, wk, bk, bp;
        logic [1:0] rsp;
        awp = 1'h1;
        wp = 1'h1;
        bp = 1'h1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        for (int t = 0; t < 64 && bp; t++) begin
            @(negedge aclk);
            ak = awp && s_axi_awready === 1'h1;
            wk = wp && s_axi_wready === 1'h1;
            bk = s_axi_bvalid === 1'h1;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (ak) begin
                awp = 1'h0;
                s_axi_awvalid <= 1'h0;
            end
            if (wk) begin
                wp = 1'h0;
                s_axi_wvalid <= 1'h0;
            end
            if (bk && s_axi_bready) begin
                bp = 1'h0;
                s_axi_bready <= 1'h0;
            end else if (bk) begin
                s_axi_bready <= 1'h1;
            end
        end
        if (bp) fail_wait();
        chk({30'h0, rsp}, {30'h0, r});
    endtask
    task automatic axi_read(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        logic ap, ak, rk, rp;
        logic [31:0] d;
        logic [1:0] rsp;
        ap = 1'h1;
        rp = 1'h1;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        for (int t = 0; t < 64 && rp; t++) begin
            @(negedge aclk);
            ak = ap && s_axi_arready === 1'h1;
            rk = s_axi_rvalid === 1'h1;
            d = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (ak) begin
                ap = 1'h0;
                s_axi_arvalid <= 1'h0;
            end
            if (rk && s_axi_rready) begin
                rp = 1'h0;
                s_axi_rready <= 1'h0;
            end else if (rk) begin
                s_axi_rready <= 1'h1;
            end
        end
        if (rp) fail_wait();
        chk(d, e);
        chk({30'h0, rsp}, {30'h0, r});
    endtask
    // Waits for the pulse total, then lets late extra pulses show up
    task automatic wait_cnt(input logic [7:0] n);
        int t;
        t = 0;
        while (n_pulses !== n && t < 20) begin
            @(negedge aclk);
            t++;
        end
        if (n_pulses !== n) fail_wait();
        repeat (4) @(negedge aclk);
        chk({24'h0, n_pulses}, {24'h0, n});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        foreach (rows[i]) begin
            axi_write(rows[i].addr, rows[i].wd, rows[i].resp);
            axi_read(rows[i].addr, rows[i].rd, rows[i].resp);
        end
        axi_write(8'h00, 32'h1, `AXI_RESP_OKAY);
        axi_write(8'h04, 32'h3, `AXI_RESP_OKAY);
        level_req <= 32'h3;
        wait_cnt(8'h02);
        chk(irq_request, 32'h1);
        chk({31'h0, irq}, 32'h1);
        axi_write(8'h14, 32'h1, `AXI_RESP_OKAY);
        @(negedge aclk);
        chk(irq_request, 32'h0);
        chk({31'h0, irq}, 32'h0);
        @(posedge aclk);
        level_req <= 32'h2;
        wait_cnt(8'h03);
        chk(irq_request, 32'h1);
        axi_write(8'h04, 32'h0, `AXI_RESP_OKAY);
        axi_write(8'h14, 32'hFFFF_FFFF, `AXI_RESP_OKAY);
        axi_write(8'h00, 32'h5, `AXI_RESP_OKAY);
        axi_write(8'h10, 32'h4, `AXI_RESP_OKAY);
        axi_read(8'h14, 32'h4, `AXI_RESP_OKAY);
        axi_read(8'h10, 32'h4, `AXI_RESP_OKAY);
        chk({24'h0, n_pulses}, 32'h3);
        axi_write(8'h14, 32'h4, `AXI_RESP_OKAY);
        axi_read(8'h10, 32'h0, `AXI_RESP_OKAY);
        axi_read(8'h14, 32'h0, `AXI_RESP_OKAY);
        // Line 0 rises so that its detected edge meets the performed select write
        level_req <= 32'h3;
        @(posedge aclk);
        axi_write(8'h08, `EDGE_SELECT_IMPL, `AXI_RESP_OKAY);
        axi_read(8'h14, 32'h0, `AXI_RESP_OKAY);
        aresetn <= 1'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        axi_read(8'h00, `RST_INTERRUPT_UNMASK, `AXI_RESP_OKAY);
        axi_read(8'h04, 32'h0, `AXI_RESP_OKAY);
        axi_read(8'h08, 32'h0, `AXI_RESP_OKAY);
        axi_read(8'h0C, 32'h0, `AXI_RESP_OKAY);
        s_axi_wstrb <= 4'h3;
        axi_write(8'h04, 32'hFFFF_FFFF, `AXI_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        axi_read(8'h04, 32'h0000_FFFF, `AXI_RESP_OKAY);
        summarize();
    end
endmodule
